// file: rtl/pce_byte_step.v
/*
 * One byte folded into the running checksum, shifted in msb first.
 * Assumes the caller has already reversed or inverted the byte as the
 * mode asks; purely combinational.
 */
`timescale 1ns/1ps
`include "pce_defines.vh"

module pce_byte_step (
   input wire [31:0] crcIn,
   input wire [7:0] dataByte,
   input wire [1:0] polySel,
   output reg [31:0] crcOut
);

   reg [31:0] wide;
   reg [15:0] narrow;
   reg [15:0] poly16;
   integer i;

   // ==========================================================
   // Eight shift steps per call
   always @* begin
      wide = crcIn ^ {dataByte, 24'h000000};
      narrow = crcIn[15:0] ^ {dataByte, 8'h00};
      poly16 = polySel[0] ? `PCE_POLY_16 : `PCE_POLY_CCITT;
      for (i = 0; i < 8; i = i + 1) begin
         wide = wide[31] ? ({wide[30:0], 1'b0} ^ `PCE_POLY_32) : {wide[30:0], 1'b0};
         narrow = narrow[15] ? ({narrow[14:0], 1'b0} ^ poly16) : {narrow[14:0], 1'b0};
      end
      // Upper bit picks the 32-bit generator
      crcOut = polySel[1] ? wide : {16'h0000, narrow};
   end

endmodule

// file: rtl/pce_crc_engine.v
/*
 * Programmable CRC engine with an AHB-Lite register slave.
 * Assumes a single AHB-Lite master, this slave's hreadyout fed back as
 * hready, and the engine's bus clock already enabled by software.
 * Only haddr[11:0] is decoded, IDLE and BUSY transfers are ignored and
 * every response is OKAY; sizes above a word are treated as a word.
 * Software that reads the checksum straight after a word write sees
 * the bus held for up to five wait states while the bytes drain.
 * Sixteen-bit modes show a zero upper half on every read.
 */
`timescale 1ns/1ps
`include "pce_defines.vh"

module pce_crc_engine (
   input wire clk_sys,
   input wire rst_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output reg [31:0] hrdata,
   output wire hresp
);

   // ==========================================================
   // Decoding helpers
   // Byte lanes touched by a transfer of the given size and address
   // Narrow transfers follow the usual little-endian lane layout
   function [3:0] laneMask;
      input [2:0] size;
      input [1:0] addr;
      begin
         case (size)
            `PCE_SIZE_BYTE: laneMask = 4'h1 << addr;
            `PCE_SIZE_HALF: laneMask = addr[1] ? 4'hc : 4'h3;
            default: laneMask = 4'hf;
         endcase
      end
   endfunction

   // Merge written lanes into an old word
   function [31:0] laneMerge;
      input [31:0] oldWord;
      input [31:0] newWord;
      input [3:0] mask;
      integer k;
      begin
         laneMerge = oldWord;
         for (k = 0; k < 4; k = k + 1) begin
            if (mask[k]) begin
               laneMerge[8 * k +: 8] = newWord[8 * k +: 8];
            end
         end
      end
   endfunction

   // Number of bytes a data write carries
   function [2:0] byteCount;
      input [2:0] size;
      begin
         case (size)
            `PCE_SIZE_BYTE: byteCount = 3'h1;
            `PCE_SIZE_HALF: byteCount = 3'h2;
            default: byteCount = 3'h4;
         endcase
      end
   endfunction

   // Word slot match of a data-phase address; shared by all three decodes
   function slotHit;
      input [11:0] addr;
      input [11:0] offset;
      begin
         slotHit = addr[11:2] == offset[11:2];
      end
   endfunction

   // ==========================================================
   // State
   reg [`PCE_MODE_W-1:0] mode;
   reg [31:0] seed;
   reg [31:0] crc;
   reg [31:0] dataBuf;
   reg [2:0] pendCount;
   // Data phase owner, captured from the accepted address phase
   reg dpActive;
   reg dpWrite;
   reg [11:0] dpAddr;
   reg [2:0] dpSize;
   reg rdValid;

   // Register slot decode of the data phase
   wire isWide = mode[`PCE_POLY_HI];
   wire [3:0] dpMask = laneMask(dpSize, dpAddr[1:0]);
   wire dpMode = slotHit(dpAddr, `PCE_OFS_MODE);
   wire dpSeed = slotHit(dpAddr, `PCE_OFS_SEED);
   wire dpSum = slotHit(dpAddr, `PCE_OFS_SUM);
   wire dpDataWr = dpActive && dpWrite && dpSum;
   wire dpSeedWr = dpActive && dpWrite && dpSeed;
   wire dpRead = dpActive && !dpWrite;

   // A new data word may enter when the last pending byte leaves now;
   // taking it earlier would need a second buffer, so the bus waits instead.
   wire canTake = pendCount <= 3'h1;
   wire dataTake = dpDataWr && canTake;

   // ==========================================================
   // Handshake outputs
   // Reads always take one wait state so that hrdata comes from a flop;
   // reads of the checksum wait further while bytes are pending.
   // Data writes hold the bus only while two or more bytes are queued.
   assign hreadyout = !(dpRead && !rdValid) && !(dpDataWr && !canTake);
   assign hresp = 1'b0;

   // ==========================================================
   // Byte preprocessing and the fold
   // Bit mirror of the lowest pending byte, one wire per bit
   wire [7:0] mirByte;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : mirror
         assign mirByte[g] = dataBuf[7 - g];
      end
   endgenerate

   // Lowest byte first; mirror before invert, as the mode asks
   reg [7:0] nextByte;
   always @* begin
      nextByte = mode[`PCE_IN_REV] ? mirByte : dataBuf[7:0];
      if (mode[`PCE_IN_INV]) begin
         nextByte = ~nextByte;
      end
   end

   // Eight shift steps of the selected generator per cycle
   wire [31:0] stepCrc;
   pce_byte_step stepUnit (
      .crcIn(crc),
      .dataByte(nextByte),
      .polySel(mode[`PCE_POLY_HI:`PCE_POLY_LO]),
      .crcOut(stepCrc)
   );

   // Seed as written in this data phase, then preprocessed
   // Lanes the write does not touch keep the stored seed
   wire [31:0] seedMerged = laneMerge(seed, hwdata, dpMask);
   wire [31:0] seedLoad;
   pce_sum_format seedFormat (
      .valueIn(seedMerged),
      .isWide(isWide),
      .doReverse(mode[`PCE_OUT_REV]),
      .doInvert(mode[`PCE_OUT_INV]),
      .valueOut(seedLoad)
   );

   // Running checksum as software sees it
   // Same shaping as the seed path, since it undoes itself
   wire [31:0] sumView;
   pce_sum_format sumFormat (
      .valueIn(crc),
      .isWide(isWide),
      .doReverse(mode[`PCE_OUT_REV]),
      .doInvert(mode[`PCE_OUT_INV]),
      .valueOut(sumView)
   );

   // ==========================================================
   // Address phase capture and data phase tracking
   // Captured only on hready, so a stalled data phase keeps its owner
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         dpActive <= 1'b0;
         dpWrite <= 1'b0;
         dpAddr <= 12'h000;
         dpSize <= 3'h0;
      end else if (hready) begin
         dpActive <= hsel && htrans[1];
         dpWrite <= hwrite;
         dpAddr <= haddr[11:0];
         dpSize <= hsize;
      end
   end

   // ==========================================================
   // Mode and seed registers
   // Byte writes reach mode only on lane 0; seed merges any lanes
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         mode <= `PCE_MODE_RESET;
         seed <= `PCE_SEED_RESET;
      end else begin
         if (dpActive && dpWrite && dpMode && dpMask[0]) begin
            mode <= hwdata[`PCE_MODE_W-1:0];
         end
         if (dpSeedWr) begin
            seed <= seedMerged;
         end
      end
   end

   // ==========================================================
   // Checksum and byte pipeline
   // Seed wins over both the byte step and any incoming data, so a
   // half-processed word is dropped rather than folded into the new seed.
   // Limitation: a mode change while bytes are pending applies to the rest
   // of that word, since the byte step reads the mode live.
   reg [31:0] next_crc;
   reg [31:0] next_dataBuf;
   reg [2:0] next_pendCount;
   always @* begin
      next_crc = crc;
      next_dataBuf = dataBuf;
      next_pendCount = pendCount;
      if (dpSeedWr) begin
         next_crc = seedLoad;
         next_pendCount = 3'h0;
      end else begin
         if (pendCount != 3'h0) begin
            next_crc = stepCrc;
            next_dataBuf = {8'h00, dataBuf[31:8]};
            next_pendCount = pendCount - 3'h1;
         end
         if (dataTake) begin
            // Narrow writes use the lane their address selects
            next_dataBuf = hwdata >> {dpAddr[1:0], 3'b000};
            next_pendCount = byteCount(dpSize);
         end
      end
   end

   // Register stage of the pipeline; only reset bypasses the next values
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         crc <= `PCE_SUM_RESET;
         dataBuf <= 32'h00000000;
         pendCount <= 3'h0;
      end else begin
         crc <= next_crc;
         dataBuf <= next_dataBuf;
         pendCount <= next_pendCount;
      end
   end

   // ==========================================================
   // Read value selection
   // Unmapped offsets read as zero with an OKAY response; the checksum is
   // only offered once no byte is left in the pipeline.
   reg [31:0] readValue;
   reg readOk;
   always @* begin
      readValue = 32'h00000000;
      readOk = 1'b1;
      if (dpMode) begin
         readValue = {26'h0, mode};
      end else if (dpSeed) begin
         readValue = isWide ? seed : {16'h0000, seed[15:0]};
      end else if (dpSum) begin
         readValue = sumView;
         readOk = pendCount == 3'h0;
      end
   end

   // ==========================================================
   // Read data register
   // Loaded once per read, so hrdata cannot move under a waiting master
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
         rdValid <= 1'b0;
      end else if (hready) begin
         rdValid <= 1'b0;
      end else if (dpRead && !rdValid && readOk) begin
         hrdata <= readValue;
         rdValid <= 1'b1;
      end
   end

endmodule

// file: rtl/pce_sum_format.v
/*
 * Reversal and ones-complement of a checksum value, over 16 or 32 bits.
 * Assumes the caller selects the width from the polynomial; combinational.
 * Both directions are their own inverse, so one block serves seed and read.
 */
`timescale 1ns/1ps

module pce_sum_format (
   input wire [31:0] valueIn,
   input wire isWide,
   input wire doReverse,
   input wire doInvert,
   output reg [31:0] valueOut
);

   reg [31:0] rev;
   integer i;

   // ==========================================================
   // Reverse, then complement, then clear unused upper half
   always @* begin
      rev = valueIn;
      for (i = 0; i < 32; i = i + 1) begin
         if (isWide) begin
            rev[i] = valueIn[31 - i];
         end else if (i < 16) begin
            rev[i] = valueIn[15 - i];
         end
      end
      valueOut = doReverse ? rev : valueIn;
      valueOut = doInvert ? ~valueOut : valueOut;
      if (!isWide) begin
         valueOut = {16'h0000, valueOut[15:0]};
      end
   end

endmodule

// file: shared/pce_defines.vh
/*
 * Constants of the programmable CRC engine: register offsets, mode field
 * positions, reset values and generator polynomials.
 * Assumes inclusion by the rtl files of the engine and by its testbench.
 */
`ifndef PCE_DEFINES_VH
`define PCE_DEFINES_VH

// ==========================================================
// Register byte offsets
`define PCE_OFS_MODE 12'h000
`define PCE_OFS_SEED 12'h004
`define PCE_OFS_SUM 12'h008

// ==========================================================
// Mode register fields
`define PCE_POLY_HI 1
`define PCE_POLY_LO 0
`define PCE_IN_REV 2
`define PCE_IN_INV 3
`define PCE_OUT_REV 4
`define PCE_OUT_INV 5
`define PCE_MODE_W 6

// ==========================================================
// Reset values
`define PCE_MODE_RESET 6'h00
`define PCE_SEED_RESET 32'h0000ffff
`define PCE_SUM_RESET 32'h0000ffff

// ==========================================================
// Generators, written without the top term
`define PCE_POLY_CCITT 16'h1021
`define PCE_POLY_16 16'h8005
`define PCE_POLY_32 32'h04c11db7

// ==========================================================
// AHB-Lite encodings
`define PCE_SIZE_BYTE 3'h0
`define PCE_SIZE_HALF 3'h1
`define PCE_SIZE_WORD 3'h2

`endif

// file: verification/pce_ahb_master.sv
/* Processor-side bus master model: single non-overlapped transfers.
   Assumes hready is the engine's own hreadyout fed back. */
`timescale 1ns/1ps
module pce_ahb_master (
   input wire clk_sys,
   input wire hready,
   input wire [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // ==========================================
   // Idle bus; engine clock taken as gated on
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
   end
   // Holds each phase until hready; stale data inverted so it cannot pass
   task automatic xfer(input logic w, input logic [11:0] a, input logic [2:0] s,
      input logic [31:0] d, output logic [31:0] r);
      hwdata <= ~hwdata;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      hsize <= s;
      @(posedge clk_sys);
      while (!hready) @(posedge clk_sys);
      htrans <= 2'h0;
      hwdata <= w ? d : ~d;
      @(posedge clk_sys);
      while (!hready) @(posedge clk_sys);
      r = hrdata;
   endtask
endmodule

// file: verification/pce_crc_engine_properties.sv
/* Bus timing and read-value checks for the CRC engine.
   Sees only the engine's ports; attached by the bind at the foot. */
`timescale 1ns/1ps
module pce_crc_engine_properties (
   input wire clk_sys,
   input wire rst_n,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire [31:0] hrdata,
   input wire hresp
);
   // ==========================================
   // Data-phase tracking
   reg dRd;
   reg dWr;
   reg wide;
   reg [11:0] dAdr;
   wire acc = hsel && htrans[1] && hready;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Owner of the data phase; wide mirrors the polynomial's top bit
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         dRd <= 1'b0;
         dWr <= 1'b0;
         wide <= 1'b0;
      end else begin
         if (dWr && hready && dAdr == 12'h000) begin
            wide <= hwdata[1];
         end
         if (hready) begin
            dRd <= acc && !hwrite;
            dWr <= acc && hwrite;
            dAdr <= haddr[11:0];
         end
      end
   end
   AST_RST_OUT: assert property ($rose(rst_n) |-> hreadyout && hrdata == 32'h0)
      else $error("outputs wrong after reset");
   AST_WR_NOWAIT: assert property (acc && hwrite && haddr[11:3] == 9'h0 |=> hreadyout)
      else $error("mode or seed write stalled");
   AST_RD_ONEWAIT: assert property (acc && !hwrite && haddr[11:0] != 12'h008
      |=> !hreadyout ##1 hreadyout) else $error("register read not one wait");
   AST_SUM_WAIT: assert property (acc && !hwrite && haddr[11:0] == 12'h008
      |=> !hreadyout ##[1:5] hreadyout) else $error("checksum read wait wrong");
   AST_DATA_WAIT: assert property (dWr && dAdr == 12'h008 && !hreadyout
      |-> ##[1:3] hreadyout) else $error("data write stalled too long");
   AST_MODE_RES: assert property (dRd && dAdr == 12'h000 && hreadyout
      |-> hrdata[31:6] == 26'h0) else $error("mode upper bits not zero");
   AST_UPPER16: assert property (dRd && !wide && hreadyout
      |-> hrdata[31:16] == 16'h0) else $error("upper half set in narrow mode");
   AST_LOW_CAUSE: assert property ($fell(hreadyout) |-> $past(acc))
      else $error("wait state without transfer");
   AST_RESP_OKAY: assert property (hresp == 1'b0)
      else $error("error response driven");
endmodule

bind pce_crc_engine pce_crc_engine_properties chk (.clk_sys(clk_sys), .rst_n(rst_n),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

// file: verification/tb_programmable_crc_engine.sv
/* Self-checking bench of the CRC engine: random modes, seeds and data.
   Assumes the master model drives the bus and the checker is bound. */
`timescale 1ns/1ps
`include "pce_defines.vh"
module tb_programmable_crc_engine;
   logic clk_sys, rst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdata, rngState, crc, seed, r;
   logic [1:0] htrans, lane;
   logic [2:0] hsize, s;
   logic [5:0] mode;
   int miscompares, testsRun, cycles;
   pce_crc_engine dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
   pce_ahb_master mst (.clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   // ==========================================
   // Reference model
   function automatic logic [31:0] rng();
      rngState = rngState ^ (rngState << 13);
      rngState = rngState ^ (rngState >> 17);
      rngState = rngState ^ (rngState << 5);
      return rngState;
   endfunction
   // Same shaping serves seed load and checksum read
   function automatic logic [31:0] fmtv(input logic [31:0] v);
      logic [31:0] t;
      int w;
      w = mode[1] ? 32 : 16;
      t = 32'h0;
      for (int i = 0; i < w; i++)
         t[i] = mode[4] ? v[w-1-i] : v[i];
      return mode[5] ? t ^ (mode[1] ? 32'hffffffff : 32'h0000ffff) : t;
   endfunction
   // Msb-first fold of one shaped byte
   function automatic logic [31:0] fold(input logic [31:0] c, input logic [7:0] d);
      logic [7:0] b;
      for (int i = 0; i < 8; i++)
         b[i] = mode[2] ? d[7-i] : d[i];
      b = mode[3] ? ~b : b;
      if (mode[1])
         c = c ^ {b, 24'h0};
      else
         c[15:0] = c[15:0] ^ {b, 8'h0};
      for (int i = 0; i < 8; i++)
         c = mode[1] ? ((c << 1) ^ (c[31] ? `PCE_POLY_32 : 32'h0)) : {16'h0, (c[15:0] << 1)
            ^ (c[15] ? (mode[0] ? `PCE_POLY_16 : `PCE_POLY_CCITT) : 16'h0)};
      return c;
   endfunction
   // ==========================================
   // Bus tasks and comparison
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic busRd(input logic [11:0] a, input logic [31:0] exp, input string what);
      mst.xfer(1'b0, a, `PCE_SIZE_WORD, 32'h0, rdata);
      check(what, rdata, exp);
   endtask
   task automatic busWr(input logic [11:0] a, input logic [2:0] sz, input logic [31:0] d);
      mst.xfer(1'b1, a, sz, d, rdata);
   endtask
   // Lanes from the address, folded lowest byte first
   task automatic dataWr(input logic [2:0] sz, input logic [1:0] ln, input logic [31:0] d);
      busWr(12'h008 | ln, sz, d);
      for (int j = 0; j < (1 << sz); j++)
         crc = fold(crc, d[8*(ln+j) +: 8]);
   endtask
   task automatic end_of_test();
      if (miscompares == 0 && testsRun > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========================================
   // Clock, hang guard and sequence
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Cuts a stalled wait short
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   initial begin
      rst_n = 1'b0;
      rngState = 32'h923f8159;
      miscompares = 0;
      testsRun = 0;
      cycles = 0;
      mode = 6'h0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      busRd(12'h000, 32'h0, "mode reset");
      busRd(12'h004, `PCE_SEED_RESET, "seed reset");
      busRd(12'h008, `PCE_SUM_RESET, "sum reset");
      busWr(12'h00c, `PCE_SIZE_WORD, 32'hffffffff);
      busRd(12'h00c, 32'h0, "unmapped");
      busRd(12'h000, 32'h0, "mode kept");
      // Halfword seed write in wide mode: only the upper lanes change
      busWr(12'h000, `PCE_SIZE_WORD, 32'h00000002);
      busWr(12'h006, `PCE_SIZE_HALF, 32'habcd1234);
      busRd(12'h004, 32'habcdffff, "seed lanes");
      busRd(12'h008, 32'habcdffff, "sum lanes");
      for (int i = 0; i < 40; i++) begin
         r = rng();
         mode = i == 0 ? 6'h00 : i == 1 ? 6'h15 : i == 2 ? 6'h36 : r[5:0];
         seed = i == 0 ? 32'h0000ffff : i == 1 ? 32'h0 : i == 2 ? 32'hffffffff : rng();
         busWr(12'h000, `PCE_SIZE_WORD, {r[31:6], mode});
         busRd(12'h000, {26'h0, mode}, "mode");
         busWr(12'h004, `PCE_SIZE_WORD, seed);
         crc = fmtv(seed);
         busRd(12'h004, mode[1] ? seed : {16'h0, seed[15:0]}, "seed");
         // Back-to-back data of every size; reads then stall on pending bytes
         repeat (r[7:6] + 1) begin
            r = rng();
            s = r[9:8] == 2'h3 ? 3'h2 : {1'b0, r[9:8]};
            lane = r[11:10] & (s == 3'h0 ? 2'h3 : s == 3'h1 ? 2'h2 : 2'h0);
            dataWr(s, lane, rng());
         end
         if (r[31]) begin
            dataWr(`PCE_SIZE_WORD, 2'h0, rng());
            busWr(12'h004, `PCE_SIZE_WORD, seed);
            crc = fmtv(seed);
         end
         busRd(12'h008, fmtv(crc), "sum");
      end
      end_of_test();
   end
endmodule
